// ===== thm_pkg.sv
/*
  Package for the thermal monitor status and configuration bank: register
  indices, field positions, reset values, timing figures and carrier structs.
  Assumes a 100 MHz core clock and an SMBus host on the two serial pins.
*/
`default_nettype none
package thm_pkg;
  // ---------------------------------------------------------------------------
  // register indices (read and write pointers)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] THM_IDX_STATUS_RD = 8'h02;
  localparam logic [7:0] THM_IDX_CFG_RD    = 8'h03;
  localparam logic [7:0] THM_IDX_CFG_WR    = 8'h09;
  localparam logic [7:0] THM_IDX_RATE_RD   = 8'h04;
  localparam logic [7:0] THM_IDX_RATE_WR   = 8'h0A;
  localparam logic [7:0] THM_IDX_ONESHOT   = 8'h0F;
  localparam logic [7:0] THM_IDX_FQ        = 8'h22;
  localparam logic [7:0] THM_IDX_PART_ID   = 8'h3D;
  localparam logic [7:0] THM_IDX_MAKER_ID  = 8'hFE;
  localparam logic [7:0] THM_IDX_REV       = 8'hFF;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int THM_CFG_MASK   = 7;
  localparam int THM_CFG_STBY   = 6;
  localparam int THM_CFG_PINSEL = 5;
  localparam int THM_CFG_BETA   = 4;
  localparam int THM_CFG_RANGE  = 2;
  localparam int THM_ST_BUSY    = 7;
  localparam int THM_FQ_SCL_TO  = 7;
  localparam int THM_FQ_SDA_TO  = 6;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] THM_CFG_RST  = 8'h08;
  localparam logic [3:0] THM_RATE_RST = 4'h6;
  localparam logic [7:0] THM_FQ_RST   = 8'h01;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int THM_CLK_PERIOD_NS = 10;
  localparam int THM_MS_NS         = 1000000;
  localparam int THM_CYC_PER_MS    = THM_MS_NS / THM_CLK_PERIOD_NS;
  localparam int THM_BUS_TO_MS     = 25;
  // conversion period in ms per rate code 0000..1010
  localparam int THM_PER_MS [11] = '{16000, 8000, 4000, 2000, 1000, 500,
                                     250, 200, 100, 50, 27};
  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic local_high;   // local above high limit
    logic local_low;    // local below low limit
    logic remote_high;  // remote above high limit
    logic remote_low;   // remote below low limit
    logic remote_open;  // remote sensor open
    logic remote_overtemp_out; // remote overtemp limit exceeded
    logic local_overtemp_out;  // local overtemp limit exceeded
    logic second_overtemp_out_hit;   // either high limit, hysteresis applied outside
  } thm_cmp_t;
  typedef struct packed {
    logic       standby;           // periodic conversions halted
    logic       beta_comp_disable; // remote beta compensation off
    logic       range_select;      // extended range
    logic [3:0] rate_code;         // conversion rate code
  } thm_ctrl_t;
endpackage
`default_nettype wire

// ===== thm_regs.sv
/*
  Status and configuration bank of a two-channel thermometer, with its SMBus
  slave, conversion pacing, fault queue and alert / overtemp pin drive.
  Assumes comparator levels and conversion-done arrive on the core clock;
  scl and sda come from pins and are resynchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module thm_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h4C,              // bus address
  parameter logic [7:0] PART_ID    = 8'h5A,              // arbitrary value
  parameter logic [7:0] MAKER_ID   = 8'hA5,              // arbitrary value
  parameter logic [7:0] REV_ID     = 8'h01,              // arbitrary value
  parameter int         CYC_PER_MS = thm_pkg::THM_CYC_PER_MS // ms prescale
) (
  input  wire logic              clock,        // core clock
  input  wire logic              srst,         // sync reset, high
  input  wire logic              scl_in,       // serial clock pin
  input  wire logic              sda_in,       // serial data pin level
  output logic                   sda_out,      // data drive value
  output logic                   sda_oe,       // data pull-down enable
  input  wire thm_pkg::thm_cmp_t cmp,          // comparator levels
  input  wire logic              conv_done,    // conversion finished
  output logic                   conv_start,   // start a conversion
  output thm_pkg::thm_ctrl_t     ctrl,         // setup to converter
  output logic                   overtemp_out, // overtemp pin level
  output logic                   overtemp_oe,  // overtemp pull-down
  output logic                   shared_out,   // shared pin level
  output logic                   shared_oe     // shared pin pull-down
);
  import thm_pkg::*;

  initial begin
    if (CYC_PER_MS < 2) $error("CYC_PER_MS too small");
  end

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  logic [7:0] cfg;
  logic [3:0] rate;
  logic [7:0] fq;
  logic [7:0] ptr;
  logic [4:0] flags;        // sticky bits 6..2
  logic [1:0] overtemp_out_flags;  // live bits 1..0
  logic       busy;
  logic       oneshot_pend;
  logic       queue_met;

  function automatic logic [2:0] fq_depth(input logic [2:0] code);
    fq_depth = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'd1;
  endfunction

  function automatic int period_ms(input logic [3:0] code);
    period_ms = (code > 4'hA) ? THM_PER_MS[10] : THM_PER_MS[code];
  endfunction

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_q;
  logic       sda_q;
  always_ff @(posedge clock) begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    scl_q    <= scl_sync[1];
    sda_q    <= sda_sync[1];
  end
  wire scl_rise = scl_sync[1] & ~scl_q;
  wire scl_fall = ~scl_sync[1] & scl_q;
  wire bus_start = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire bus_stop  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // ---------------------------------------------------------------------------
  // millisecond tick and bus timeouts
  // ---------------------------------------------------------------------------
  logic [31:0] pre_cnt;
  logic        ms_tick;
  logic [5:0]  scl_low_ms;
  logic [5:0]  sda_low_ms;
  logic        bus_timeout;
  always_ff @(posedge clock) begin
    if (srst || pre_cnt == 32'(CYC_PER_MS - 1)) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 32'd1;
    end
    ms_tick <= !srst && pre_cnt == 32'(CYC_PER_MS - 1);
  end

  // low-time counters restart whenever the line rises
  always_ff @(posedge clock) begin
    if (srst || scl_sync[1]) begin
      scl_low_ms <= '0;
    end else if (ms_tick && scl_low_ms != 6'h3F) begin
      scl_low_ms <= scl_low_ms + 6'd1;
    end
    if (srst || sda_sync[1]) begin
      sda_low_ms <= '0;
    end else if (ms_tick && sda_low_ms != 6'h3F) begin
      sda_low_ms <= sda_low_ms + 6'd1;
    end
  end
  assign bus_timeout = (fq[THM_FQ_SCL_TO] && scl_low_ms >= 6'(THM_BUS_TO_MS))
                    || (fq[THM_FQ_SDA_TO] && sda_low_ms >= 6'(THM_BUS_TO_MS));

  // ---------------------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    THM_S_IDLE = 7'b0000001,
    THM_S_ADDR = 7'b0000010,
    THM_S_ACKA = 7'b0000100,
    THM_S_WR   = 7'b0001000,
    THM_S_ACKW = 7'b0010000,
    THM_S_RD   = 7'b0100000,
    THM_S_ACKR = 7'b1000000
  } thm_state_t;
  thm_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic       rnw;
  logic       first_byte;
  logic       host_ack;
  logic [7:0] rd_data;
  logic       byte_wr;     // one-cycle: data byte received
  logic       rd_load;     // one-cycle: read byte loaded

  // read decode, live state on busy and overtemp bits
  always_comb begin
    unique case (ptr)
      THM_IDX_STATUS_RD: rd_data = {busy, flags, overtemp_out_flags};
      THM_IDX_CFG_RD:    rd_data = cfg;
      THM_IDX_RATE_RD:   rd_data = {4'h0, rate};
      THM_IDX_FQ:        rd_data = fq;
      THM_IDX_PART_ID:   rd_data = PART_ID;
      THM_IDX_MAKER_ID:  rd_data = MAKER_ID;
      THM_IDX_REV:       rd_data = REV_ID;
      default:           rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    byte_wr <= 1'b0;
    rd_load <= 1'b0;
    if (srst || bus_stop || bus_timeout) begin
      state  <= THM_S_IDLE;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state      <= THM_S_ADDR;
      bit_cnt    <= '0;
      first_byte <= 1'b1;
      sda_oe     <= 1'b0;
    end else begin
      unique case (state)
        THM_S_IDLE: sda_oe <= 1'b0;
        THM_S_ADDR, THM_S_WR: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 4'd1;
          end else if (scl_fall && bit_cnt == 4'd8) begin
            if (state == THM_S_ADDR) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                rnw    <= shreg[0];
                sda_oe <= 1'b1;
                state  <= THM_S_ACKA;
              end else begin
                state <= THM_S_IDLE;
              end
            end else begin
              byte_wr <= 1'b1;
              sda_oe  <= 1'b1;
              state   <= THM_S_ACKW;
            end
          end
        end
        THM_S_ACKA, THM_S_ACKW: begin
          if (scl_fall) begin
            bit_cnt <= '0;
            if (state == THM_S_ACKW) begin
              first_byte <= 1'b0;
            end
            if (state == THM_S_ACKA && rnw) begin
              shreg   <= rd_data;
              rd_load <= 1'b1;
              sda_oe  <= ~rd_data[7];
              state   <= THM_S_RD;
            end else begin
              sda_oe <= 1'b0;
              state  <= THM_S_WR;
            end
          end
        end
        THM_S_RD: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'd1;
          end else if (scl_fall && bit_cnt == 4'd8) begin
            sda_oe <= 1'b0;
            state  <= THM_S_ACKR;
          end else if (scl_fall) begin
            shreg  <= {shreg[6:0], 1'b0};
            sda_oe <= ~shreg[6];
          end
        end
        THM_S_ACKR: begin
          if (scl_rise) begin
            host_ack <= ~sda_sync[1];
          end else if (scl_fall && host_ack) begin
            // pointer does not advance; the same register repeats
            shreg   <= rd_data;
            rd_load <= 1'b1;
            sda_oe  <= ~rd_data[7];
            bit_cnt <= '0;
            state   <= THM_S_RD;
          end else if (scl_fall) begin
            state <= THM_S_IDLE;
          end
        end
      endcase
    end
  end
  assign sda_out = 1'b0;

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  // pointer from first data byte, no reset value
  always_ff @(posedge clock) begin
    if (byte_wr && first_byte) begin
      ptr <= shreg;
    end
  end

  wire reg_wr = byte_wr && !first_byte;
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg  <= THM_CFG_RST;
      rate <= THM_RATE_RST;
      fq   <= THM_FQ_RST;
    end else if (reg_wr) begin
      if (ptr == THM_IDX_CFG_WR) begin
        cfg <= {shreg[7:4], 1'b1, shreg[2], 2'b00};
      end
      if (ptr == THM_IDX_RATE_WR) begin
        rate <= shreg[3:0];
      end
      if (ptr == THM_IDX_FQ) begin
        fq <= {shreg[7:6], 2'b00, shreg[3:1], 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // conversion pacing
  // ---------------------------------------------------------------------------
  logic [15:0] per_cnt;
  wire standby = cfg[THM_CFG_STBY];
  wire due     = ms_tick && per_cnt >= 16'(period_ms(rate) - 1);

  // one-shot request held until a conversion starts
  always_ff @(posedge clock) begin
    if (srst || conv_start) begin
      oneshot_pend <= 1'b0;
    end else if (reg_wr && ptr == THM_IDX_ONESHOT && standby) begin
      oneshot_pend <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || due) begin
      per_cnt <= '0;
    end else if (ms_tick) begin
      per_cnt <= per_cnt + 16'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      conv_start <= 1'b0;
      busy       <= 1'b0;
    end else begin
      conv_start <= !busy && !conv_start && ((due && !standby) || oneshot_pend);
      if (conv_start) begin
        busy <= 1'b1;
      end else if (conv_done) begin
        busy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // fault queue and flags
  // ---------------------------------------------------------------------------
  logic [2:0] fault_cnt;
  wire [4:0] trip = {cmp.local_high, cmp.local_low, cmp.remote_high,
                     cmp.remote_low, cmp.remote_open};
  wire status_rd = rd_load && ptr == THM_IDX_STATUS_RD;
  // queue depth reached at this conversion
  // widened so a saturated count still meets the depth
  wire queue_hit = conv_done && |trip
                && ((4'(fault_cnt) + 4'd1) >= 4'(fq_depth(fq[3:1])));

  always_ff @(posedge clock) begin
    if (srst || (conv_done && !(|trip))) begin
      fault_cnt <= '0;
    end else if (conv_done && fault_cnt != 3'd7) begin
      fault_cnt <= fault_cnt + 3'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      flags     <= '0;
      queue_met <= 1'b0;
    end else begin
      flags     <= (status_rd ? 5'h00 : flags)
                 | ((queue_hit || standby) ? trip : 5'h00);
      queue_met <= (status_rd ? 1'b0 : queue_met) || queue_hit || (standby && |trip);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      overtemp_out_flags <= '0;
    end else begin
      overtemp_out_flags <= {cmp.remote_overtemp_out, cmp.local_overtemp_out};
    end
  end

  // ---------------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------------
  wire pin_sel = cfg[THM_CFG_PINSEL];
  wire alert_req = !cfg[THM_CFG_MASK] && queue_met && |flags;

  // overtemp pin, and shared pin when pin_sel is set, follow live comparisons, even in standby
  always_ff @(posedge clock) begin
    if (srst) begin
      overtemp_oe <= 1'b0;
      shared_oe   <= 1'b0;
    end else begin
      overtemp_oe <= cmp.remote_overtemp_out || cmp.local_overtemp_out;
      shared_oe   <= pin_sel ? cmp.second_overtemp_out_hit : alert_req;
    end
  end
  assign overtemp_out = 1'b0;
  assign shared_out   = 1'b0;

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl <= '{standby: 1'b0, beta_comp_disable: 1'b0, range_select: 1'b0,
                rate_code: THM_RATE_RST};
    end else begin
      ctrl <= '{standby: standby, beta_comp_disable: cfg[THM_CFG_BETA],
                range_select: cfg[THM_CFG_RANGE], rate_code: rate};
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  property p_mask;
    @(posedge clock) disable iff (srst)
      (cfg[THM_CFG_MASK] && !pin_sel) |=> !shared_oe;
  endproperty
  a_mask: assert property (p_mask) else $error("alert not masked");

  property p_standby;
    @(posedge clock) disable iff (srst)
      (standby && !oneshot_pend) ##1 (standby && !oneshot_pend) |-> !conv_start;
  endproperty
  a_standby: assert property (p_standby) else $error("conversion in standby");

  property p_overtemp;
    @(posedge clock) disable iff (srst)
      (cmp.local_overtemp_out || cmp.remote_overtemp_out) |=> overtemp_oe;
  endproperty
  a_overtemp: assert property (p_overtemp) else $error("overtemp not driven");

  property p_second_overtemp_out;
    @(posedge clock) disable iff (srst)
      (pin_sel && cfg[THM_CFG_MASK]) |=> (shared_oe == $past(cmp.second_overtemp_out_hit));
  endproperty
  a_second_overtemp_out: assert property (p_second_overtemp_out) else $error("second overtemp wrong");

  property p_cfg_wr;
    @(posedge clock) disable iff (srst)
      (reg_wr && ptr == THM_IDX_CFG_WR) |=> (cfg[THM_CFG_MASK] == $past(shreg[7]));
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");

  property p_ptr;
    @(posedge clock) disable iff (srst)
      (byte_wr && first_byte) |=> (ptr == $past(shreg));
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not loaded");

  property p_sticky;
    @(posedge clock) disable iff (srst)
      (flags[4] && !status_rd) |=> flags[4];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped");

  property p_busy;
    @(posedge clock) disable iff (srst)
      (conv_start && !conv_done) |=> busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set");

  property p_no_alert;
    @(posedge clock) disable iff (srst)
      (!pin_sel && flags == 5'h00) |=> !shared_oe;
  endproperty
  a_no_alert: assert property (p_no_alert) else $error("alert without flag");

  property p_rate_rst;
    @(posedge clock) srst |=> (rate == THM_RATE_RST && cfg == THM_CFG_RST);
  endproperty
  a_rate_rst: assert property (p_rate_rst) else $error("bad reset values");
endmodule
`default_nettype wire

// ===== thm_host.sv
/*
  SMBus host model for the thermal monitor bank: bit-banged master tasks.
  Assumes the bench resolves the open-drain data line and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module thm_host (
  input  wire logic clock,   // core clock
  output logic      scl,     // serial clock
  output logic      sda_low, // host pulls data low
  input  wire logic sda      // resolved data line
);
  // ---------------------------------------------------------------------------
  // clock stands high between frames, data released
  // ---------------------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit: data set mid-low, sampled just before the fall
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    s = sda;
    scl <= 1'b0;
  endtask
  // byte msb first, then ack slot with data released
  task automatic xfer(input logic [7:0] v, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
      r[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic start_c();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop_c();
    tick(2);
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_low <= 1'b0;
    tick(8);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                        output logic ack);
    logic [7:0] r;
    logic       k0, k1, k2;
    start_c();
    xfer({a, 1'b0}, r, k0);
    xfer(idx, r, k1);
    xfer(d, r, k2);
    stop_c();
    ack = k0 & k1 & k2;
  endtask
  // pointer load, then a read that ends with a nack
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] v);
    logic [7:0] r;
    logic       k;
    start_c();
    xfer({a, 1'b0}, r, k);
    xfer(idx, r, k);
    stop_c();
    start_c();
    xfer({a, 1'b1}, r, k);
    xfer(8'hFF, v, k);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
/*
  Testbench for the thermal monitor bank: register sequences over SMBus.
  Assumes thm_host as bus master and a fixed-latency converter model here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import thm_pkg::*;
  localparam logic [6:0] ADR = 7'h4C;
  logic       clock = 1'b0;
  logic       srst, conv_done, scl, host_low, sda, sda_out, sda_oe, conv_start, ack;
  logic       overtemp_out, overtemp_oe, shared_out, shared_oe;
  thm_cmp_t   cmp;
  thm_ctrl_t  ctrl;
  logic [7:0] v;
  int         mismatches, n_checks, n_conv, cd_cnt, cyc, t0;
  // open drain with pull-up
  assign sda = ~(host_low | sda_oe);
  always #5 clock = ~clock;
  // ids below are arbitrary
  thm_regs #(.PART_ID(8'h3C), .MAKER_ID(8'hC3), .REV_ID(8'h07), .CYC_PER_MS(10)) dut (
    .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .cmp(cmp), .conv_done(conv_done), .conv_start(conv_start),
    .ctrl(ctrl), .overtemp_out(overtemp_out), .overtemp_oe(overtemp_oe),
    .shared_out(shared_out), .shared_oe(shared_oe));
  thm_host host (.clock(clock), .scl(scl), .sda_low(host_low), .sda(sda));
  // ---------------------------------------------------------------------------
  // converter model: done 20 cycles after start
  // ---------------------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    conv_done <= 1'b0;
    if (conv_start) begin
      cd_cnt <= 20;
    end else if (cd_cnt != 0) begin
      cd_cnt <= cd_cnt - 1;
      conv_done <= (cd_cnt == 1);
      n_conv <= n_conv + (cd_cnt == 1);
    end
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.wr_reg(ADR, idx, d, ack);
    check("ack", 16'(ack), 16'd1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    host.rd_reg(ADR, idx, v);
    check(nm, 16'(v & m), 16'(e));
  endtask
  // bounded wait for n more conversions
  task automatic wait_conv(input int n);
    int t;
    t = n_conv + n;
    for (int i = 0; i < 3000 && n_conv < t; i++) @(posedge clock);
    check("conv", 16'(n_conv), 16'(t));
    repeat (3) @(posedge clock);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    complete_run();
  end
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    cmp = '0;
    conv_done = 1'b0;
    cd_cnt = 0;
    cyc = 0;
    n_conv = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(THM_IDX_CFG_RD, 8'hFF, THM_CFG_RST, "cfg");
    rd(THM_IDX_RATE_RD, 8'hFF, 8'h06, "rate");
    rd(THM_IDX_FQ, 8'hFF, THM_FQ_RST, "fq");
    rd(THM_IDX_PART_ID, 8'hFF, 8'h3C, "part");
    rd(THM_IDX_MAKER_ID, 8'hFF, 8'hC3, "maker");
    rd(THM_IDX_REV, 8'hFF, 8'h07, "rev");
    rd(8'h50, 8'hFF, 8'h00, "unmapped");
    host.wr_reg(7'h4D, THM_IDX_CFG_WR, 8'hFF, ack);
    check("nak", 16'(ack), 16'd0);
    wr(THM_IDX_CFG_WR, 8'hF4);
    wr(THM_IDX_CFG_RD, 8'h00);
    rd(THM_IDX_CFG_RD, 8'hFF, 8'hFC, "cfg_w");
    check("ctrl", 16'(ctrl), 16'h0076);
    t0 = n_conv;
    cmp.second_overtemp_out_hit <= 1'b1;
    repeat (600) @(posedge clock);
    check("stby", 16'(n_conv), 16'(t0));
    check("pin2", 16'(shared_oe), 16'd1);
    cmp.second_overtemp_out_hit <= 1'b0;
    t0 = n_conv;
    wr(THM_IDX_ONESHOT, 8'h00);
    repeat (40) @(posedge clock);
    check("oneshot", 16'(n_conv), 16'(t0 + 1));
    wr(THM_IDX_RATE_WR, 8'hFA);
    rd(THM_IDX_RATE_RD, 8'hFF, 8'h0A, "rate_w");
    wr(THM_IDX_CFG_WR, 8'h00);
    wait_conv(1);
    t0 = cyc;
    wait_conv(1);
    check("period", 16'(cyc - t0), 16'd270);
    cmp.local_high <= 1'b1;
    cmp.local_overtemp_out <= 1'b1;
    wait_conv(2);
    check("alert", 16'(shared_oe), 16'd1);
    check("overtemp_out", 16'(overtemp_oe), 16'd1);
    cmp <= '0;
    wait_conv(1);
    rd(THM_IDX_STATUS_RD, 8'h7F, 8'h40, "stat");
    rd(THM_IDX_STATUS_RD, 8'h7F, 8'h00, "stat_clr");
    check("alert_off", 16'(shared_oe), 16'd0);
    wr(THM_IDX_CFG_WR, 8'h80);
    cmp.remote_open <= 1'b1;
    wait_conv(2);
    check("masked", 16'(shared_oe), 16'd0);
    cmp <= '0;
    rd(THM_IDX_STATUS_RD, 8'h7F, 8'h04, "open");
    wr(THM_IDX_CFG_WR, 8'h00);
    wr(THM_IDX_FQ, 8'h0E);
    rd(THM_IDX_FQ, 8'hFF, 8'h0F, "fq_w");
    wait_conv(1);
    cmp.remote_high <= 1'b1;
    wait_conv(3);
    check("fq3", 16'(shared_oe), 16'd0);
    wait_conv(1);
    check("fq4", 16'(shared_oe), 16'd1);
    wr(THM_IDX_FQ, 8'hC1);
    rd(THM_IDX_FQ, 8'hFF, 8'hC1, "tmo");
    complete_run();
  end
endmodule
`default_nettype wire
